// *** src/smd_pkg.sv ***
// Purpose: shared constants for the sector map discovery block
// Assumes: 32-bit AHB-Lite register bus, byte-wide configuration registers
// Notes:   descriptor dwords are built from their fields, not typed as opaque words

package smd_pkg;

  // ---------------------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] SMD_OFF_ARCH_NV   = 8'h00;
  localparam logic [7:0] SMD_OFF_BOOT_NV   = 8'h04;
  localparam logic [7:0] SMD_OFF_TBL_PTR   = 8'h08;
  localparam logic [7:0] SMD_OFF_TBL_DATA  = 8'h0C;
  localparam logic [7:0] SMD_OFF_ANY_ADDR  = 8'h10;
  localparam logic [7:0] SMD_OFF_ANY_DATA  = 8'h14;
  localparam logic [7:0] SMD_OFF_MAP_STAT  = 8'h18;

  // ---------------------------------------------------------------------------
  // configuration register layout and reset values
  // ---------------------------------------------------------------------------
  localparam int         SMD_UNIFORM_BIT   = 3;
  localparam int         SMD_TOP_BOT_BIT   = 2;
  localparam logic [7:0] SMD_ARCH_NV_RST   = 8'h00;
  localparam logic [7:0] SMD_BOOT_NV_RST   = 8'h00;
  localparam logic [31:0] SMD_ARCH_NV_ADDR = 32'h0000_0004;
  localparam logic [31:0] SMD_BOOT_NV_ADDR = 32'h0000_0002;

  // table pointer: byte offset in [7:0], alternate-table view in [8]
  localparam int         SMD_PTR_VIEW_BIT  = 8;
  localparam logic [7:0] SMD_ALT_SHIFT     = 8'h02;

  // status layout: index in [7:0], valid flag in [8]
  localparam int         SMD_STAT_VALID_BIT = 8;

  // ---------------------------------------------------------------------------
  // map index values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] SMD_IDX_HYB_BOTTOM = 8'h01;
  localparam logic [7:0] SMD_IDX_HYB_TOP    = 8'h03;
  localparam logic [7:0] SMD_IDX_UNIFORM    = 8'h05;

  // ---------------------------------------------------------------------------
  // detection descriptor fields
  // ---------------------------------------------------------------------------
  localparam logic [7:0] SMD_OPC_READ_ANY  = 8'h65;
  localparam logic [1:0] SMD_ADDRLEN_VAR   = 2'b11;
  localparam logic [3:0] SMD_LAT_VAR       = 4'hF;
  localparam logic [1:0] SMD_RFU2          = 2'b11;
  localparam logic [5:0] SMD_RFU6          = 6'h3F;
  localparam logic       SMD_TYPE_CMD      = 1'b0;
  localparam logic       SMD_NOT_END       = 1'b0;
  localparam logic [7:0] SMD_MASK_ARCH     = 8'h08;
  localparam logic [7:0] SMD_MASK_BOOT     = 8'h04;

  localparam logic [7:0] SMD_TBL_BASE      = 8'h48;
  localparam int         SMD_TBL_DWORDS    = 4;
  localparam logic [7:0] SMD_TBL_BYTES     = 8'h10;

  localparam logic [31:0] SMD_DET1_CMD = {SMD_MASK_ARCH, SMD_ADDRLEN_VAR, SMD_RFU2,
                                          SMD_LAT_VAR, SMD_OPC_READ_ANY, SMD_RFU6,
                                          SMD_TYPE_CMD, SMD_NOT_END};
  localparam logic [31:0] SMD_DET2_CMD = {SMD_MASK_BOOT, SMD_ADDRLEN_VAR, SMD_RFU2,
                                          SMD_LAT_VAR, SMD_OPC_READ_ANY, SMD_RFU6,
                                          SMD_TYPE_CMD, SMD_NOT_END};

  typedef logic [31:0] smd_dword_t;

  localparam smd_dword_t SMD_TABLE [SMD_TBL_DWORDS] = '{
    SMD_DET1_CMD, SMD_ARCH_NV_ADDR, SMD_DET2_CMD, SMD_BOOT_NV_ADDR
  };

endpackage : smd_pkg

// *** src/smd_descriptor_rom.sv ***
// Purpose: byte-addressed view of the sector map detection descriptors
// Assumes: offset is relative to the start of the discoverable parameter table
// Notes:   bytes outside the stored span read as zero

`timescale 1ns/1ns

module smd_descriptor_rom (
  input  wire logic [7:0] i_offset,
  output logic      [7:0] o_byte
);

  // ---------------------------------------------------------------------------
  // lookup
  // ---------------------------------------------------------------------------
  logic [7:0] rel;
  logic       in_span;
  logic [1:0] dw_sel;
  logic [1:0] by_sel;
  logic [31:0] dword;

  assign rel     = i_offset - smd_pkg::SMD_TBL_BASE;
  assign in_span = (i_offset >= smd_pkg::SMD_TBL_BASE) && (rel < smd_pkg::SMD_TBL_BYTES);
  assign dw_sel  = rel[3:2];
  assign by_sel  = rel[1:0];
  assign dword   = smd_pkg::SMD_TABLE[dw_sel];

  // little-endian byte order within each dword
  assign o_byte  = in_span ? dword[{by_sel, 3'b000} +: 8] : 8'h00;

endmodule : smd_descriptor_rom

// *** src/smd_core.sv ***
// Purpose: sector map discovery support behind an AHB-Lite register port
// Assumes: single zero-wait transfers, whole words only, response always OKAY
// Notes:   configuration bytes live in flops here; nonvolatile storage is elsewhere

`timescale 1ns/1ns

module smd_core (
  input  wire logic        I_MCLK,
  input  wire logic        I_RESET,
  input  wire logic        I_HSEL,
  input  wire logic [31:0] I_HADDR,
  input  wire logic [1:0]  I_HTRANS,
  input  wire logic        I_HWRITE,
  input  wire logic [2:0]  I_HSIZE,
  input  wire logic [31:0] I_HWDATA,
  input  wire logic        I_HREADY,
  output logic      [31:0] O_HRDATA,
  output logic             O_HREADYOUT,
  output logic             O_HRESP
);

  // ---------------------------------------------------------------------------
  // address match helper, shared by both phases
  // ---------------------------------------------------------------------------
  function automatic logic hit(input logic [31:0] addr, input logic [7:0] off);
    hit = (addr[31:8] == 24'h00_0000) && (addr[7:0] == off);
  endfunction : hit

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  logic [7:0]  arch_nv_r;
  logic [7:0]  arch_nv_nxt;
  logic [7:0]  boot_nv_r;
  logic [7:0]  boot_nv_nxt;
  logic [8:0]  ptr_r;
  logic [8:0]  ptr_nxt;
  logic [31:0] any_addr_r;
  logic [31:0] any_addr_nxt;
  logic        wr_pend_r;
  logic [31:0] wr_addr_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  // ---------------------------------------------------------------------------
  // bus phase decode
  // ---------------------------------------------------------------------------
  logic addr_valid;
  logic rd_take;
  logic wr_take;
  logic rd_tbl_data;

  // htrans[1] covers NONSEQ and SEQ; hsize is accepted as-is, only words are used
  assign addr_valid  = I_HSEL && I_HTRANS[1] && I_HREADY;
  assign rd_take     = addr_valid && !I_HWRITE;
  assign wr_take     = addr_valid && I_HWRITE;
  assign rd_tbl_data = rd_take && hit(I_HADDR, smd_pkg::SMD_OFF_TBL_DATA);

  logic wr_arch;
  logic wr_boot;
  logic wr_ptr;
  logic wr_any;

  assign wr_arch = wr_pend_r && hit(wr_addr_r, smd_pkg::SMD_OFF_ARCH_NV);
  assign wr_boot = wr_pend_r && hit(wr_addr_r, smd_pkg::SMD_OFF_BOOT_NV);
  assign wr_ptr  = wr_pend_r && hit(wr_addr_r, smd_pkg::SMD_OFF_TBL_PTR);
  assign wr_any  = wr_pend_r && hit(wr_addr_r, smd_pkg::SMD_OFF_ANY_ADDR);

  // ---------------------------------------------------------------------------
  // map index assembly
  // ---------------------------------------------------------------------------
  logic       uniform_map_select_bit;
  logic       parameter_sector_top_bottom_bit;
  logic [7:0] map_index;
  logic       map_valid;

  assign uniform_map_select_bit          = arch_nv_r[smd_pkg::SMD_UNIFORM_BIT];
  assign parameter_sector_top_bottom_bit = boot_nv_r[smd_pkg::SMD_TOP_BOT_BIT];

  // index bits sit above a constant one: 0b0ab1 gives 01h, 03h, 05h, 07h
  assign map_index = {5'b00000, uniform_map_select_bit,
                      parameter_sector_top_bottom_bit, 1'b1};

  // uniform with top sectors (07h) has no published map
  assign map_valid = (map_index == smd_pkg::SMD_IDX_HYB_BOTTOM) ||
                     (map_index == smd_pkg::SMD_IDX_HYB_TOP)    ||
                     (map_index == smd_pkg::SMD_IDX_UNIFORM);

  // ---------------------------------------------------------------------------
  // descriptor table window
  // ---------------------------------------------------------------------------
  logic [7:0] tbl_offset;
  logic [7:0] tbl_byte;

  // alternate view sits two bytes above the primary table
  assign tbl_offset = ptr_r[smd_pkg::SMD_PTR_VIEW_BIT] ?
                      (ptr_r[7:0] - smd_pkg::SMD_ALT_SHIFT) : ptr_r[7:0];

  smd_descriptor_rom u_rom (
    .i_offset (tbl_offset),
    .o_byte   (tbl_byte)
  );

  // ---------------------------------------------------------------------------
  // read any register emulation
  // ---------------------------------------------------------------------------
  logic [7:0] any_byte;

  assign any_byte = (any_addr_r == smd_pkg::SMD_ARCH_NV_ADDR) ? arch_nv_r :
                    (any_addr_r == smd_pkg::SMD_BOOT_NV_ADDR) ? boot_nv_r :
                    8'h00;

  // ---------------------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------------------
  logic [31:0] status_word;

  assign status_word = {23'h00_0000, map_valid, map_index};

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (!rd_take) begin
      rdata_nxt = 32'h0000_0000;
    end else if (hit(I_HADDR, smd_pkg::SMD_OFF_ARCH_NV)) begin
      rdata_nxt = {24'h00_0000, arch_nv_r};
    end else if (hit(I_HADDR, smd_pkg::SMD_OFF_BOOT_NV)) begin
      rdata_nxt = {24'h00_0000, boot_nv_r};
    end else if (hit(I_HADDR, smd_pkg::SMD_OFF_TBL_PTR)) begin
      rdata_nxt = {23'h00_0000, ptr_r};
    end else if (hit(I_HADDR, smd_pkg::SMD_OFF_TBL_DATA)) begin
      rdata_nxt = {24'h00_0000, tbl_byte};
    end else if (hit(I_HADDR, smd_pkg::SMD_OFF_ANY_ADDR)) begin
      rdata_nxt = any_addr_r;
    end else if (hit(I_HADDR, smd_pkg::SMD_OFF_ANY_DATA)) begin
      rdata_nxt = {24'h00_0000, any_byte};
    end else if (hit(I_HADDR, smd_pkg::SMD_OFF_MAP_STAT)) begin
      rdata_nxt = status_word;
    end else begin
      rdata_nxt = 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------------------
  // register next values
  // ---------------------------------------------------------------------------
  assign arch_nv_nxt  = wr_arch ? I_HWDATA[7:0] : arch_nv_r;
  assign boot_nv_nxt  = wr_boot ? I_HWDATA[7:0] : boot_nv_r;
  assign any_addr_nxt = wr_any  ? I_HWDATA      : any_addr_r;

  // a table read steps the pointer so a host can stream bytes;
  // the view bit is kept, the offset wraps at the byte boundary
  assign ptr_nxt = wr_ptr      ? I_HWDATA[8:0] :
                   rd_tbl_data ? {ptr_r[smd_pkg::SMD_PTR_VIEW_BIT], ptr_r[7:0] + 8'h01} :
                   ptr_r;

  // ---------------------------------------------------------------------------
  // flops
  // ---------------------------------------------------------------------------
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      arch_nv_r  <= smd_pkg::SMD_ARCH_NV_RST;
      boot_nv_r  <= smd_pkg::SMD_BOOT_NV_RST;
      ptr_r      <= 9'h000;
      any_addr_r <= 32'h0000_0000;
    end else begin
      arch_nv_r  <= arch_nv_nxt;
      boot_nv_r  <= boot_nv_nxt;
      ptr_r      <= ptr_nxt;
      any_addr_r <= any_addr_nxt;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 32'h0000_0000;
    end else begin
      wr_pend_r <= wr_take;
      wr_addr_r <= wr_take ? I_HADDR : wr_addr_r;
    end
  end

  // never stalls, never errors
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      rdata_r     <= 32'h0000_0000;
      O_HREADYOUT <= 1'b1;
      O_HRESP     <= 1'b0;
    end else begin
      rdata_r     <= rdata_nxt;
      O_HREADYOUT <= 1'b1;
      O_HRESP     <= 1'b0;
    end
  end

  assign O_HRDATA = rdata_r;

endmodule : smd_core

// *** verification/smd_checker.sv ***
// Purpose: bus-side property checks for smd_core
// Assumes: master inserts an IDLE cycle after every transfer
// Notes:   shadow flops follow writes so read data can be tied to them
`timescale 1ns/1ns
module smd_checker (
  input wire logic        I_MCLK,
  input wire logic        I_RESET,
  input wire logic        I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0]  I_HTRANS,
  input wire logic        I_HWRITE,
  input wire logic [31:0] I_HWDATA,
  input wire logic        I_HREADY,
  input wire logic [31:0] O_HRDATA,
  input wire logic        O_HREADYOUT,
  input wire logic        O_HRESP
);
  logic        rd_r;
  logic        wr_r;
  logic [7:0]  a_r;
  logic [7:0]  arch_r;
  logic [7:0]  boot_r;
  logic [31:0] any_r;
  wire         take  = I_HSEL && I_HTRANS[1] && I_HREADY;
  wire  [7:0]  any_x = (any_r == 32'h4) ? arch_r : (any_r == 32'h2) ? boot_r : 8'h00;
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      {rd_r, wr_r, arch_r, boot_r, any_r} <= '0;
    end else begin
      rd_r <= take && !I_HWRITE;
      wr_r <= take && I_HWRITE;
      // upper address bits set map to an offset nothing decodes
      a_r  <= (I_HADDR[31:8] != 24'h0) ? 8'hFF : I_HADDR[7:0];
      if (wr_r && a_r == 8'h00) arch_r <= I_HWDATA[7:0];
      if (wr_r && a_r == 8'h04) boot_r <= I_HWDATA[7:0];
      if (wr_r && a_r == 8'h10) any_r <= I_HWDATA;
    end
  end
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RESET);
  property p_ready; O_HREADYOUT && !O_HRESP; endproperty
  a_ready: assert property (p_ready) else $error("bus not ready or not okay");
  property p_idle; !rd_r |-> O_HRDATA == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside read");
  property p_arch; rd_r && a_r == 8'h00 |-> O_HRDATA == {24'h0, arch_r}; endproperty
  a_arch: assert property (p_arch) else $error("arch register mismatch");
  property p_boot; rd_r && a_r == 8'h04 |-> O_HRDATA == {24'h0, boot_r}; endproperty
  a_boot: assert property (p_boot) else $error("boot register mismatch");
  property p_idx; rd_r && a_r == 8'h18 |-> O_HRDATA[7:0] == {5'h0, arch_r[3], boot_r[2], 1'b1};
  endproperty
  a_idx: assert property (p_idx) else $error("map index mismatch");
  property p_valid; rd_r && a_r == 8'h18 |-> O_HRDATA[31:8] == {23'h0, !(arch_r[3] && boot_r[2])};
  endproperty
  a_valid: assert property (p_valid) else $error("map valid flag mismatch");
  property p_any; rd_r && a_r == 8'h14 |-> O_HRDATA == {24'h0, any_x}; endproperty
  a_any: assert property (p_any) else $error("read-any data mismatch");
  property p_unmap; rd_r && a_r > 8'h18 |-> O_HRDATA == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_tbl; take && !I_HWRITE && I_HADDR == 32'hC |=> O_HRDATA[31:8] == 24'h0 ##1 !rd_r;
  endproperty
  a_tbl: assert property (p_tbl) else $error("table read too wide");
endmodule : smd_checker

bind smd_core smd_checker u_chk (.I_MCLK(I_MCLK), .I_RESET(I_RESET), .I_HSEL(I_HSEL),
  .I_HADDR(I_HADDR), .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE), .I_HWDATA(I_HWDATA),
  .I_HREADY(I_HREADY), .O_HRDATA(O_HRDATA), .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP));

// *** verification/smd_host.sv ***
// Purpose: host model that discovers the sector map over the bus
// Assumes: single word transfers, waits for ready without a fixed count
// Notes:   address is scrambled in the data phase so a stale bus is caught
`timescale 1ns/1ns
module smd_host (
  input  wire logic        i_clk,
  input  wire logic        i_hready,
  input  wire logic [31:0] i_hrdata,
  output logic             o_hsel,
  output logic [31:0]      o_haddr,
  output logic [1:0]       o_htrans,
  output logic             o_hwrite,
  output logic [2:0]       o_hsize,
  output logic [31:0]      o_hwdata
);
  initial begin
    {o_hsel, o_haddr, o_htrans, o_hwrite, o_hwdata} = '0;
    o_hsize = 3'b010;
  end
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    o_hsel   <= 1'b1;
    o_haddr  <= a;
    o_htrans <= 2'b10;
    o_hwrite <= wr;
    do @(posedge i_clk); while (i_hready !== 1'b1);
    o_htrans <= 2'b00;
    o_haddr  <= ~a;
    o_hwdata <= d;
    do @(posedge i_clk); while (i_hready !== 1'b1);
    q = i_hrdata;
  endtask : xfer
  // masked detection bytes joined, architecture bit above location bit
  function automatic logic [31:0] map_index(input logic [7:0] ra, rb, ma, mb);
    logic [7:0] idx;
    idx = {5'h0, |(ra & ma), |(rb & mb), 1'b1};
    map_index = {23'h0, idx inside {8'h01, 8'h03, 8'h05}, idx};
  endfunction : map_index
endmodule : smd_host

// *** verification/tb_top.sv ***
// Purpose: self-checking bench for smd_core
// Assumes: zero wait slave, host model drives the bus
// Notes:   corner settings first, then random ones from the lfsr
`timescale 1ns/1ns
module tb_top;
  logic        mclk, rst, hsel, hwrite, hready, hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [15:0] lfsr;
  int          bad_count, num_checks;
  always #10 mclk = ~mclk;
  smd_core u_dut (.I_MCLK(mclk), .I_RESET(rst), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata),
    .I_HREADY(hready), .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp));
  smd_host u_host (.i_clk(mclk), .i_hready(hready), .i_hrdata(hrdata), .o_hsel(hsel),
    .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite), .o_hsize(hsize), .o_hwdata(hwdata));
  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    lfsr_step = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_step
  function automatic logic [7:0] tbl_byte(input int k);
    logic [31:0] dw [4];
    dw = '{32'h08FF65FC, 32'h0000_0004, 32'h04FF65FC, 32'h0000_0002};
    tbl_byte = dw[k / 4][8 * (k % 4) +: 8];
  endfunction : tbl_byte
  function automatic logic [31:0] exp_stat(input logic [7:0] a, b);
    exp_stat = {23'h0, !(a[3] && b[2]), 5'h0, a[3], b[2], 1'b1};
  endfunction : exp_stat
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    u_host.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    u_host.xfer(1'b0, a, {lfsr, lfsr}, q);
    chk(q, e);
    chk({31'h0, hresp}, 32'h0);
  endtask : rdc
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (5000) @(posedge mclk);
    bad_count++;
    $display("Error at %0t: got %h expected %h", $time, 32'h0, 32'h1);
    summarize();
  end
  initial begin
    logic [31:0] q, qa, qb;
    logic [7:0]  a, b, m1, m2, ad1, ad2, lv;
    {mclk, rst, lfsr, bad_count, num_checks} = {2'b01, 16'h000B, 64'h0};
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    for (int i = 0; i < 7; i++) rdc(4 * i, (i == 6) ? 32'h101 : 32'h0);
    $display("reset values done");
    // both table views, one byte below the span first
    for (int v = 0; v < 2; v++) begin
      wr(32'h8, {23'h0, v[0], 8'h47 + 8'(2 * v)});
      for (int k = 0; k < 17; k++) begin
        u_host.xfer(1'b0, 32'hC, {lfsr, lfsr}, q);
        chk(q, (k == 0) ? 32'h0 : {24'h0, tbl_byte(k - 1)});
        if (k == 3) lv = q[7:0];
        if (k == 4) m1 = q[7:0];
        if (k == 5) ad1 = q[7:0];
        if (k == 12) m2 = q[7:0];
        if (k == 13) ad2 = q[7:0];
      end
      // host reads both fields as variable: own address length and dummy count
      chk({24'h0, lv[7:6], 2'b00, lv[3:0]}, {24'h0, 2'b11, 2'b00, 4'hF});
      rdc(32'h8, {23'h0, v[0], 8'h58 + 8'(2 * v)});
    end
    $display("descriptor table done");
    for (int i = 0; i < 12; i++) begin
      lfsr = lfsr_step(lfsr);
      a = (i < 4) ? {4'h0, i[1], 3'h0} : lfsr[7:0];
      b = (i < 4) ? {5'h0, i[0], 2'h0} : lfsr[15:8];
      wr(32'h0, {lfsr, lfsr[15:8], a});
      wr(32'h4, {lfsr, lfsr[7:0], b});
      rdc(32'h0, {24'h0, a});
      rdc(32'h4, {24'h0, b});
      wr(32'h10, {24'h0, ad1});
      u_host.xfer(1'b0, 32'h14, {lfsr, lfsr}, qa);
      wr(32'h10, {24'h0, ad2});
      u_host.xfer(1'b0, 32'h14, {lfsr, lfsr}, qb);
      chk(qa, {24'h0, a});
      chk(u_host.map_index(qa[7:0], qb[7:0], m1, m2), exp_stat(a, b));
      rdc(32'h18, exp_stat(a, b));
    end
    $display("configuration sweep done");
    wr(32'h1C, 32'hFFFF_FFFF);
    wr(32'h18, 32'h0);
    wr(32'h10, 32'h0000_0104);
    rdc(32'h14, 32'h0);
    rdc(32'h1C, 32'h0);
    rdc(32'h100, 32'h0);
    rdc(32'h0, {24'h0, a});
    rdc(32'h18, exp_stat(a, b));
    $display("refusals done");
    summarize();
  end
endmodule : tb_top
